// ---- dv/lrp_board_model.sv ----
`default_nettype none

// ----------------------------------------
// Board side: detectors and loop clock
// ----------------------------------------
module lrp_board_model (
  input  wire logic       clock,
  output var  logic [2:0] lock_detect,
  output var  logic [3:0] loss,
  output var  logic       active_ref_is_b,
  output var  logic       third_loop_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet board at power up
  initial
  begin
    lock_detect = 3'h0;
    loss = 4'h0;
    active_ref_is_b = 1'b0;
    third_loop_clock = 1'b0;
  end
  // Loop clock runs free at half the core rate
  always @(posedge clock)
    third_loop_clock <= ~third_loop_clock;
  // Detector levels change just after an edge, as real ones may at any time
  task automatic set_state(input logic [2:0] lk, input logic [3:0] ls, input logic ab);
    lock_detect <= lk;
    loss <= ls;
    active_ref_is_b <= ab;
  endtask
endmodule

`default_nettype wire

// ---- dv/lrp_pin_chk.sv ----
`default_nettype none

// ----------------------------------------
// Port checker of the pin control
// ----------------------------------------
module lrp_pin_chk (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  lock_detect,
  input wire logic        loss_ref_a,
  input wire logic        loss_ref_b,
  input wire logic        loss_loop_two,
  input wire logic        loss_loop_three,
  input wire logic        active_ref_is_b,
  input wire logic        own_out_invert,
  input wire logic        third_loop_clock,
  input wire logic        first_lock_pin,
  input wire logic        ref_loss_pin,
  input wire logic        third_loop_output_zero,
  input wire logic        repurpose_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lk_r;  // Shadow of lock config
  logic [7:0] ls_r;  // Shadow of loss config
  logic [7:0] rp_r;  // Shadow of repurpose config
  logic [1:0] up_r;  // Edges since reset, saturating
  logic [3:0] det;   // Detectors in the order ref a, ref b, loop two, loop three
  assign det = {loss_loop_three, loss_loop_two, loss_ref_b, loss_ref_a};
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // OR of enabled sources; bit 2 picks the active reference
  function automatic logic reference_loss(input logic [7:0] en, input logic [3:0] d, input logic ab);
    return |(en[4:0] & {d[3], d[2], (ab ? d[1] : d[0]), d[1], d[0]});
  endfunction

  // Shadows avoid bus reads; pins lag the sync chain until up_r saturates
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      lk_r <= 8'h00;
      ls_r <= 8'h00;
      rp_r <= 8'h00;
      up_r <= 2'h0;
    end
    else
    begin
      up_r <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
      if (psel && penable && pwrite && paddr == 12'h20c)
        lk_r <= pwdata[7:0] & 8'h3f;
      if (psel && penable && pwrite && paddr == 12'h210)
        ls_r <= pwdata[7:0] & 8'h7f;
      if (psel && penable && pwrite && paddr == 12'h214)
        rp_r <= pwdata[7:0] & 8'h7f;
    end
  end

  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_idle;
    !penable |-> !pready && !pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("answer outside access phase");
  property p_okaddr;
    psel && penable && paddr inside {12'h20c, 12'h210, 12'h214} |-> !pslverr;
  endproperty
  a_okaddr: assert property (p_okaddr) else $error("error on mapped register");
  property p_lock1;
    up_r == 2'h3 |-> first_lock_pin == ($past(lock_detect[0], 3) ^ $past(lk_r[0]));
  endproperty
  a_lock1: assert property (p_lock1) else $error("first lock pin level wrong");
  property p_loss;
    up_r == 2'h3 |-> ref_loss_pin == (reference_loss($past(ls_r), $past(det, 3), $past(active_ref_is_b, 3)) ^ $past(ls_r[5]));
  endproperty
  a_loss: assert property (p_loss) else $error("loss pin level wrong");
  property p_norm;
    !repurpose_active |-> third_loop_output_zero == (third_loop_clock ^ own_out_invert);
  endproperty
  a_norm: assert property (p_norm) else $error("output not the plain clock");
  property p_ract;
    up_r == 2'h3 |-> repurpose_active == (|$past(rp_r[4:0]));
  endproperty
  a_ract: assert property (p_ract) else $error("repurpose state wrong");
  property p_rlvl;
    repurpose_active && up_r == 2'h3 |->
      third_loop_output_zero == (reference_loss($past(rp_r), $past(det, 3), $past(active_ref_is_b, 3)) ^ $past(rp_r[5]));
  endproperty
  a_rlvl: assert property (p_rlvl) else $error("repurposed level wrong");
endmodule

bind lrp_pin_ctrl lrp_pin_chk u_chk (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .lock_detect(lock_detect), .loss_ref_a(loss_ref_a), .loss_ref_b(loss_ref_b), .loss_loop_two(loss_loop_two),
  .loss_loop_three(loss_loop_three), .active_ref_is_b(active_ref_is_b), .own_out_invert(own_out_invert),
  .third_loop_clock(third_loop_clock), .first_lock_pin(first_lock_pin), .ref_loss_pin(ref_loss_pin),
  .third_loop_output_zero(third_loop_output_zero), .repurpose_active(repurpose_active));

`default_nettype wire

// ---- dv/lrp_pin_ctrl_test.sv ----
`default_nettype none

// ----------------------------------------
// Bench of the pin control
// ----------------------------------------
module lrp_pin_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A0 = 12'h20c;  // First config word
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic own_out_invert = 1'b1;
  logic own_out_hv = 1'b1;
  logic [2:0] lock_detect, lock_pin_hv;
  logic [3:0] loss;
  logic active_ref_is_b, third_loop_clock, first_lock_pin, second_lock_pin, third_lock_pin;
  logic ref_loss_pin, ref_loss_pin_hv, third_loop_output_zero, third_loop_output_zero_hv, repurpose_active;
  logic [7:0] en, rp, v;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  lrp_pin_ctrl DUT (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lock_detect(lock_detect), .loss_ref_a(loss[0]), .loss_ref_b(loss[1]), .loss_loop_two(loss[2]),
    .loss_loop_three(loss[3]), .active_ref_is_b(active_ref_is_b), .own_out_invert(own_out_invert),
    .own_out_hv(own_out_hv), .third_loop_clock(third_loop_clock), .first_lock_pin(first_lock_pin),
    .second_lock_pin(second_lock_pin), .third_lock_pin(third_lock_pin), .lock_pin_hv(lock_pin_hv),
    .ref_loss_pin(ref_loss_pin), .ref_loss_pin_hv(ref_loss_pin_hv), .third_loop_output_zero(third_loop_output_zero),
    .third_loop_output_zero_hv(third_loop_output_zero_hv), .repurpose_active(repurpose_active), .irq(irq));

  lrp_board_model u_board (.clock(clock), .lock_detect(lock_detect), .loss(loss),
    .active_ref_is_b(active_ref_is_b), .third_loop_clock(third_loop_clock));

  // Expected OR of enabled loss sources
  function automatic logic reference_loss(input logic [7:0] e, input logic [3:0] d, input logic ab);
    return |(e[4:0] & {d[3], d[2], (ab ? d[1] : d[0]), d[1], d[0]});
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the slave decides when it answers
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    xfer(a, 1'b1, d, q, e);
  endtask

  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] q;
    logic e;
    xfer(a, 1'b0, 8'h00, q, e);
    check(nm, q, x);
    check("pslverr", {31'h0, e}, {31'h0, ex});
  endtask

  task automatic settle(input logic [2:0] lk, input logic [3:0] ls, input logic ab);
    u_board.set_state(lk, ls, ab);
    repeat (4) @(posedge clock);
  endtask

  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 5; i++)
      rc("reset_value", A0 + 12'(4 * i), 32'h0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wr(A0 + 12'(4 * i), 8'hff);
      rc("reserved", A0 + 12'(4 * i), (i == 0) ? 32'h3f : 32'h7f, 1'b0);
    end
    rc("unmapped", 12'h400, 32'h0, 1'b1);
    // Every sense and drive combination of the lock pins
    settle(3'b101, 4'h0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'(8'h15 * i);
      wr(A0, v);
      repeat (4) @(posedge clock);
      check("lock_pins", {29'h0, third_lock_pin, second_lock_pin, first_lock_pin}, {29'h0, 3'b101 ^ {v[4], v[2], v[0]}});
      check("lock_hv", {29'h0, lock_pin_hv}, {29'h0, v[5], v[3], v[1]});
    end
    // Each source alone, both senses; repurpose uses a different source
    for (int i = 0; i < 10; i++)
    begin
      en = 8'(1 << (i % 5)) | 8'((i / 5) * 8'h60);
      rp = 8'(1 << ((i + 1) % 5)) | 8'((1 - i / 5) * 8'h60);
      wr(A0 + 12'h4, en);
      wr(A0 + 12'h8, rp);
      for (int d = 0; d < 32; d++)
      begin
        settle(3'b111, 4'(d), d[4]);
        check("ref_loss", {31'h0, ref_loss_pin}, {31'h0, reference_loss(en, 4'(d), d[4]) ^ en[5]});
        check("repurpose", {30'h0, repurpose_active, third_loop_output_zero}, {30'h0, 1'b1, reference_loss(rp, 4'(d), d[4]) ^ rp[5]});
        check("drive", {30'h0, ref_loss_pin_hv, third_loop_output_zero_hv}, {30'h0, en[6], rp[6]});
      end
    end
    // No enables: plain clock with its own settings
    wr(A0 + 12'h8, 8'h20);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      own_out_invert <= i[0];
      @(negedge clock);
      check("normal", {29'h0, repurpose_active, third_loop_output_zero, third_loop_output_zero_hv},
        {29'h0, 1'b0, third_loop_clock ^ own_out_invert, own_out_hv});
    end
    // Events, masking and write-one-to-clear
    @(posedge clock);
    settle(3'b111, 4'h0, 1'b0);
    wr(A0 + 12'hc, 8'h7f);
    settle(3'b110, 4'h1, 1'b0);
    rc("status", A0 + 12'hc, 32'h09, 1'b0);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(A0 + 12'h10, 8'h09);
    check("irq_set", {31'h0, irq}, 32'h1);
    wr(A0 + 12'hc, 8'h09);
    rc("status_clr", A0 + 12'hc, 32'h0, 1'b0);
    check("irq_clr", {31'h0, irq}, 32'h0);
    stop_test();
  end
endmodule

`default_nettype wire

// ---- hdl/lrp_pin_ctrl.sv ----
`include "lrp_params.svh"
`default_nettype none

module lrp_pin_ctrl (
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`LRP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Detector inputs, asynchronous to clock
  input  wire logic [2:0]             lock_detect,
  input  wire logic                   loss_ref_a,
  input  wire logic                   loss_ref_b,
  input  wire logic                   loss_loop_two,
  input  wire logic                   loss_loop_three,
  input  wire logic                   active_ref_is_b,
  // Own output settings of the third loop output, same clock
  input  wire logic                   own_out_invert,
  input  wire logic                   own_out_hv,
  // Ordinary clock of the third loop output
  input  wire logic                   third_loop_clock,
  // Pins
  output var  logic                   first_lock_pin,
  output var  logic                   second_lock_pin,
  output var  logic                   third_lock_pin,
  output var  logic [2:0]             lock_pin_hv,
  output var  logic                   ref_loss_pin,
  output var  logic                   ref_loss_pin_hv,
  output logic                        third_loop_output_zero,
  output var  logic                   third_loop_output_zero_hv,
  output var  logic                   repurpose_active,
  output logic                        irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lrp_pkg::lrp_byte_type lock_cfg_r;     // Lock pin sense and drive
  lrp_pkg::lrp_byte_type loss_cfg_r;     // Loss pin enables, sense, drive
  lrp_pkg::lrp_byte_type repur_cfg_r;    // Repurpose enables, sense, drive
  lrp_pkg::lrp_byte_type irq_mask_r;     // Interrupt mask
  logic [`LRP_EVT_W-1:0] irq_status_r;   // Sticky event bits
  logic [`LRP_EVT_W-1:0] irq_status_nxt; // Next sticky value
  logic [`LRP_EVT_W-1:0] evt;            // Events this cycle

  logic [7:0]            meta_r;         // First synchroniser stage
  logic [7:0]            sync_r;         // Second synchroniser stage
  logic [7:0]            sync_d_r;       // Delayed copy for edges
  logic [7:0]            raw_in;         // Raw asynchronous inputs
  logic [2:0]            lock_s;         // Synchronised lock state
  lrp_pkg::lrp_det_type  det_s;          // Synchronised loss detectors
  logic                  act_b_s;        // Synchronised active reference

  logic                  loss_any;       // Loss pin OR before sense
  logic                  repur_any;      // Repurpose OR before sense
  logic                  repur_en;       // Any repurpose enable set
  logic                  static_level_r; // Registered repurpose level

  logic                  setup_ph;       // APB setup cycle
  logic                  wr_acc;         // Write taking effect
  logic [7:0]            idx;            // Word index from address
  logic                  idx_hit;        // Mapped address
  logic [7:0]            wbyte;          // Write data byte
  logic [2:0]            lock_pin_nxt;   // Lock pin levels
  logic [2:0]            lock_hv_nxt;    // Lock pin drive levels

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Loss OR over enabled sources; shared by the pin and repurpose
  function automatic logic loss_or(
    input logic [`LRP_SRC_W-1:0] en,
    input lrp_pkg::lrp_det_type  det,
    input logic                  act_b
  );
    logic active_loss;
    begin
      active_loss = act_b ? det[1] : det[0];
      loss_or = (en[`LRP_SRC_REF_A] & det[0])
              | (en[`LRP_SRC_REF_B] & det[1])
              | (en[`LRP_SRC_ACTIVE] & active_loss)
              | (en[`LRP_SRC_LOOP_TWO] & det[2])
              | (en[`LRP_SRC_LOOP_THREE] & det[3]);
    end
  endfunction

  // Index decode, used by write and read paths
  function automatic logic idx_mapped(input logic [7:0] i);
    begin
      idx_mapped = (i == `LRP_IDX_LOCK_CFG)
                 | (i == `LRP_IDX_LOSS_CFG)
                 | (i == `LRP_IDX_REPUR_CFG)
                 | (i == `LRP_IDX_IRQ_STATUS)
                 | (i == `LRP_IDX_IRQ_MASK);
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Detectors sit in analog domains, so every one passes two flops
  assign raw_in = {active_ref_is_b, loss_loop_three, loss_loop_two,
                   loss_ref_b, loss_ref_a, lock_detect};

  // Two stage synchroniser; only sync_r reads meta_r
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end
    else
    begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  // Delayed copy for event edge detection
  always_ff @(posedge clock)
  begin
    if (!resetn)
      sync_d_r <= 8'h00;
    else
      sync_d_r <= sync_r;
  end

  assign lock_s  = sync_r[2:0];
  assign det_s   = sync_r[6:3];
  assign act_b_s = sync_r[7];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Registered read data costs a setup cycle, so no wait states
  assign setup_ph = psel & ~penable;
  assign idx      = paddr[9:2];
  assign idx_hit  = idx_mapped(idx) & (paddr[`LRP_ADDR_W-1:10] == 2'h0)
                  & (paddr[1:0] == 2'h0);
  assign wr_acc   = psel & penable & pwrite & idx_hit;
  assign wbyte    = pwdata[7:0];
  // Always ready in the access phase
  assign pready   = psel & penable;
  // Unmapped addresses answer with an error
  assign pslverr  = psel & penable & ~idx_hit;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // reserved bits masked on write
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      lock_cfg_r  <= `LRP_RST_LOCK_CFG;
      loss_cfg_r  <= `LRP_RST_LOSS_CFG;
      repur_cfg_r <= `LRP_RST_REPUR_CFG;
      irq_mask_r  <= `LRP_RST_IRQ_MASK;
    end
    else if (wr_acc)
    begin
      case (idx)
        `LRP_IDX_LOCK_CFG:  lock_cfg_r  <= wbyte & `LRP_LOCK_CFG_MASK;
        `LRP_IDX_LOSS_CFG:  loss_cfg_r  <= wbyte & `LRP_LOSS_CFG_MASK;
        `LRP_IDX_REPUR_CFG: repur_cfg_r <= wbyte & `LRP_LOSS_CFG_MASK;
        `LRP_IDX_IRQ_MASK:  irq_mask_r  <= wbyte & `LRP_EVT_MASK;
        // Status handled in its own process
        default:            lock_cfg_r  <= lock_cfg_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Captured in setup so the access phase can finish at once
  always_ff @(posedge clock)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (setup_ph && !pwrite)
    begin
      case (idx)
        `LRP_IDX_LOCK_CFG:   prdata <= {24'h00_0000, lock_cfg_r};
        `LRP_IDX_LOSS_CFG:   prdata <= {24'h00_0000, loss_cfg_r};
        `LRP_IDX_REPUR_CFG:  prdata <= {24'h00_0000, repur_cfg_r};
        `LRP_IDX_IRQ_STATUS: prdata <= {25'h000_0000, irq_status_r};
        `LRP_IDX_IRQ_MASK:   prdata <= {24'h00_0000, irq_mask_r};
        // Reads of an unmapped word index return zero
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events and status
  // ----------------------------------------------------------------
  // Lock lost on a falling lock; loss onset on a rising detector
  assign evt = {det_s & ~sync_d_r[6:3], ~lock_s & sync_d_r[2:0]};

  // Write one to clear; a new event in the same cycle wins
  always_comb
  begin
    irq_status_nxt = irq_status_r;
    if (wr_acc && (idx == `LRP_IDX_IRQ_STATUS))
      irq_status_nxt = irq_status_r & ~wbyte[`LRP_EVT_W-1:0];
    irq_status_nxt = irq_status_nxt | evt;
  end

  // Sticky status register
  always_ff @(posedge clock)
  begin
    if (!resetn)
      irq_status_r <= {`LRP_EVT_W{1'b0}};
    else
      irq_status_r <= irq_status_nxt;
  end

  // Level interrupt while any unmasked bit is set
  assign irq = |(irq_status_r & irq_mask_r[`LRP_EVT_W-1:0]);

  // ----------------------------------------------------------------
  // Lock indication pins
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_lock
      assign lock_pin_nxt[g] = lock_s[g]
        ^ lock_cfg_r[`LRP_LOCK_INV_BIT0 + `LRP_LOCK_STRIDE*g];

      assign lock_hv_nxt[g] = lock_cfg_r[`LRP_LOCK_HV_BIT0 + `LRP_LOCK_STRIDE*g];
    end
  endgenerate

  // Registered lock pins; one process so the drive vector has one writer
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      first_lock_pin  <= 1'b0;
      second_lock_pin <= 1'b0;
      third_lock_pin  <= 1'b0;
      lock_pin_hv     <= 3'h0;
    end
    else
    begin
      first_lock_pin  <= lock_pin_nxt[0];
      second_lock_pin <= lock_pin_nxt[1];
      third_lock_pin  <= lock_pin_nxt[2];
      lock_pin_hv     <= lock_hv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reference-loss pin
  // ----------------------------------------------------------------
  // OR of enabled detectors
  assign loss_any = loss_or(loss_cfg_r[`LRP_SRC_W-1:0], det_s, act_b_s);

  // Pin level and drive
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ref_loss_pin    <= 1'b0;
      ref_loss_pin_hv <= 1'b0;
    end
    else
    begin
      ref_loss_pin    <= loss_any ^ loss_cfg_r[`LRP_LOSS_INV_BIT];
      ref_loss_pin_hv <= loss_cfg_r[`LRP_LOSS_HV_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Third loop output zero repurpose
  // ----------------------------------------------------------------
  // same source map as pin
  assign repur_any = loss_or(repur_cfg_r[`LRP_SRC_W-1:0], det_s, act_b_s);
  assign repur_en  = |repur_cfg_r[`LRP_SRC_W-1:0];

  // Static level, mode flag and drive level
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      static_level_r            <= 1'b0;
      repurpose_active          <= 1'b0;
      third_loop_output_zero_hv <= 1'b0;
    end
    else
    begin
      static_level_r   <= repur_any ^ repur_cfg_r[`LRP_LOSS_INV_BIT];
      repurpose_active <= repur_en;
      if (repur_en)
        third_loop_output_zero_hv <= repur_cfg_r[`LRP_LOSS_HV_BIT];
      else
        third_loop_output_zero_hv <= own_out_hv;
    end
  end

  // The clock path cannot be registered at this rate, so the
  // output is a mux; the select is a flop to keep it glitch-light
  // normal clock when idle
  assign third_loop_output_zero = repurpose_active ? static_level_r
                                                   : (third_loop_clock ^ own_out_invert);

endmodule

`default_nettype wire

// ---- include/lrp_params.svh ----
`ifndef LRP_PARAMS_SVH
`define LRP_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses (byte address = 4 * index)
// ----------------------------------------------------------------
`define LRP_IDX_LOCK_CFG    8'h83
`define LRP_IDX_LOSS_CFG    8'h84
`define LRP_IDX_REPUR_CFG   8'h85
`define LRP_IDX_IRQ_STATUS  8'h86
`define LRP_IDX_IRQ_MASK    8'h87
`define LRP_ADDR_W          12

// ----------------------------------------------------------------
// Lock pin configuration fields
// ----------------------------------------------------------------
`define LRP_LOCK_INV_BIT0   0
`define LRP_LOCK_HV_BIT0    1
`define LRP_LOCK_STRIDE     2
`define LRP_LOCK_CFG_MASK   8'h3f

// ----------------------------------------------------------------
// Reference-loss and repurpose configuration fields
// ----------------------------------------------------------------
`define LRP_SRC_REF_A       0
`define LRP_SRC_REF_B       1
`define LRP_SRC_ACTIVE      2
`define LRP_SRC_LOOP_TWO    3
`define LRP_SRC_LOOP_THREE  4
`define LRP_SRC_W           5
`define LRP_LOSS_INV_BIT    5
`define LRP_LOSS_HV_BIT     6
`define LRP_LOSS_CFG_MASK   8'h7f

// ----------------------------------------------------------------
// Interrupt status layout: lock lost [2:0], loss onset [6:3]
// ----------------------------------------------------------------
`define LRP_EVT_W           7
`define LRP_EVT_MASK        8'h7f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LRP_RST_LOCK_CFG    8'h00
`define LRP_RST_LOSS_CFG    8'h00
`define LRP_RST_REPUR_CFG   8'h00
`define LRP_RST_IRQ_MASK    8'h00

`endif

// ---- include/lrp_pkg.sv ----
`default_nettype none

// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package lrp_pkg;
  // One configuration byte
  typedef logic [7:0] lrp_byte_type;
  // Raw loss detector vector: ref a, ref b, loop two, loop three
  typedef logic [3:0] lrp_det_type;
endpackage

`default_nettype wire
